// ===== core/snf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module snf_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic clk_i, // System clock
    input wire logic arst_n_i, // Asynchronous reset
    input wire logic [W-1:0] in_data_i, // Write word
    input wire logic in_valid_i, // Write request
    output logic in_ready_o, // Room available
    output logic [W-1:0] out_data_o, // Head word
    output logic out_valid_o, // Head present
    input wire logic out_ready_i // Consumer takes head
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    // Depth must be a power of two so pointers wrap on their own
    assign in_ready_o = count != (AW+1)'(D);
    assign out_valid_o = count != '0;
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
            rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ===== core/snf_front.sv
`timescale 1ns/1ps
`default_nettype none
module snf_front #(
    parameter int LOCKOUT_CYCLES = snf_pkg::LOCKOUT_CYCLES
) (
    input wire logic clk_i, // System clock, 25 MHz
    input wire logic arst_n_i, // Power-on reset
    input wire logic cs_n_i, // Chip select pin
    input wire logic sclk_i, // Serial clock pin
    input wire logic [3:0] io_i, // Data lines in
    output logic [3:0] io_o, // Data lines out
    output logic [3:0] io_oe_o, // Data line drive enables
    output var snf_pkg::snf_cmd_t cmd_o, // Accepted array command
    output logic cmd_valid_o, // Command pulse
    input wire logic op_done_i, // Array operation finished
    input wire logic [7:0] rd_data_i, // Read byte from buffer
    input wire logic rd_valid_i, // Read byte present
    output logic rd_ready_o, // Read byte taken
    output logic [7:0] load_data_o, // Loaded byte
    output logic load_valid_o, // Loaded byte present
    input wire logic load_ready_i, // Consumer takes byte
    output logic load_overflow_o, // Byte lost on full buffer
    output var snf_pkg::snf_regs_t regs_o, // Register images
    output logic paused_o, // Pause in force
    output logic lockout_o // Power-up write lockout
);
    import snf_pkg::*;

    // Edges per byte, less one
    function automatic logic [2:0] last_edge(input snf_width_t w);
        case (w)
            SNF_W2: last_edge = 3'h3;
            SNF_W4: last_edge = 3'h1;
            default: last_edge = 3'h7;
        endcase
    endfunction

    function automatic logic [2:0] addr_bytes(input logic [7:0] op);
        case (op)
            OP_RDREG_A, OP_RDREG_B, OP_WRREG_A, OP_WRREG_B: addr_bytes = 3'h1;
            OP_PLOAD, OP_PLOAD_Q, OP_PLOAD_QR: addr_bytes = 3'h2;
            OP_PEXEC, OP_ERASE: addr_bytes = 3'h3;
            OP_READ_S, OP_READ_D, OP_READ_DIO: addr_bytes = 3'h3;
            OP_READ_Q, OP_READ_QIO: addr_bytes = 3'h3;
            OP_BBM: addr_bytes = 3'h4;
            default: addr_bytes = 3'h0;
        endcase
    endfunction

    function automatic snf_width_t op_width(input logic [7:0] op);
        case (op)
            OP_READ_D, OP_READ_DIO: op_width = SNF_W2;
            OP_READ_Q, OP_READ_QIO, OP_PLOAD_Q, OP_PLOAD_QR: op_width = SNF_W4;
            default: op_width = SNF_W1;
        endcase
    endfunction

    // Phase that follows the last address byte
    function automatic snf_state_t phase_after(input logic [7:0] op);
        case (op)
            OP_RDREG_A, OP_RDREG_B: phase_after = ST_DOUT;
            OP_READ_S, OP_READ_D, OP_READ_DIO: phase_after = ST_DOUT;
            OP_READ_Q, OP_READ_QIO: phase_after = ST_DOUT;
            OP_WRREG_A, OP_WRREG_B: phase_after = ST_DIN;
            OP_PLOAD, OP_PLOAD_Q, OP_PLOAD_QR: phase_after = ST_DIN;
            default: phase_after = ST_IGN;
        endcase
    endfunction

    function automatic logic blk_protected(input logic [9:0] blk, input logic [3:0] bp,
                                           input logic tb);
        logic [10:0] span;
        logic [10:0] off;
        span = 11'h000;
        off = 11'h000;
        if (bp >= BP_ALL) begin
            span = 11'h400;
        end else if (bp != 4'h0) begin
            span = 11'h001 << bp;
        end
        // Distance from the protected end of the array
        off = tb ? {1'b0, blk} : 11'h3FF - {1'b0, blk};
        blk_protected = off < span;
    endfunction

    snf_state_t state;
    snf_state_t next_state;
    snf_width_t width;
    snf_width_t in_w;
    logic [5:0] pin_s;
    logic sclk_q;
    logic paused;
    logic quad_mode;
    logic [2:0] bitcnt;
    logic [7:0] sh_in;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [2:0] addr_left;
    logic [7:0] out_sh;
    logic [2:0] out_cnt;
    logic out_on;
    logic write_enable_latch;
    logic busy;
    logic pe_op;
    logic [7:0] prot;
    logic [7:0] conf;
    logic [7:0] stat3;
    logic [31:0] lock_cnt;
    logic [7:0] next_in;
    logic [7:0] reg_byte;
    logic [7:0] byte_out;
    logic overflow;
    logic fifo_ready;

    // Every pin crosses into the system clock before use
    snf_sync #(.W(6), .INIT(SYNC_INIT)) u_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i({cs_n_i, sclk_i, io_i}),
        .q_o(pin_s)
    );

    wire cs_act = ~pin_s[5];
    wire sclk_s = pin_s[4];
    wire [3:0] io_s = pin_s[3:0];

    // Clock edges count only while selected and not paused
    wire rise = sclk_s & ~sclk_q & cs_act & ~paused;
    wire fall = ~sclk_s & sclk_q & cs_act & ~paused;

    // Protection decode
    wire wpe = prot[PROT_WPE_BIT];
    wire [1:0] srp = {prot[PROT_REG_PROTECT_BIT1_BIT], prot[PROT_REG_PROTECT_BIT0_BIT]};
    wire [3:0] bp = prot[PROT_BP_LSB+3:PROT_BP_LSB];
    wire wp_low = ~io_s[2];
    wire hw_ro = wpe & wp_low;
    wire wr_block = lockout_o | hw_ro;

    // Input shifter; address and opcode always arrive on one line
    assign in_w = (state == ST_DIN) ? width : SNF_W1;
    always_comb begin
        case (in_w)
            SNF_W2: next_in = {sh_in[5:0], io_s[1:0]};
            SNF_W4: next_in = {sh_in[3:0], io_s};
            default: next_in = {sh_in[6:0], io_s[0]};
        endcase
    end

    wire in_done = rise && (bitcnt == last_edge(in_w));
    wire op_dec = in_done && state == ST_OPC;
    wire [2:0] op_abytes = addr_bytes(next_in);
    wire op_quad = op_width(next_in) == SNF_W4;
    wire addr_last = in_done && state == ST_ADDR && addr_left == 3'h1;
    wire [31:0] addr_n = {addr[23:0], next_in};
    wire is_rdreg = opcode == OP_RDREG_A || opcode == OP_RDREG_B;
    wire is_wrreg = opcode == OP_WRREG_A || opcode == OP_WRREG_B;
    wire is_pe = opcode == OP_PEXEC || opcode == OP_ERASE;
    wire is_exec = is_pe || opcode == OP_BBM;
    wire din_byte = in_done && state == ST_DIN;

    // Decode: quad opcodes are dropped when the protect enable is set
    always_comb begin
        next_state = state;
        case (state)
            ST_OPC: begin
                if (op_dec) begin
                    next_state = (op_abytes == 3'h0 || (op_quad && wpe)) ? ST_IGN : ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (addr_last) begin
                    next_state = phase_after(opcode);
                end
            end
            ST_DIN: begin
                if (din_byte && is_wrreg) begin
                    next_state = ST_IGN;
                end
            end
            ST_DOUT, ST_IGN: next_state = state;
            default: next_state = ST_IGN;
        endcase
    end

    // Sequencer; deselect discards the instruction, pause just freezes it
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_OPC;
        end else if (!cs_act) begin
            state <= ST_OPC;
        end else begin
            state <= next_state;
        end
    end

    // Serial clock history for edge finding
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk_s;
        end
    end

    // Pause: waits for a low clock so a high-phase bit is not torn
    wire hold_low = ~io_s[3] & ~quad_mode;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            paused <= 1'b0;
        end else if (!cs_act) begin
            paused <= 1'b0;
        end else if (paused) begin
            paused <= hold_low;
        end else begin
            paused <= hold_low & ~sclk_s;
        end
    end

    // Bit counter and input shift register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bitcnt <= 3'h0;
            sh_in <= 8'h00;
        end else if (!cs_act) begin
            bitcnt <= 3'h0;
        end else if (rise) begin
            bitcnt <= in_done ? 3'h0 : bitcnt + 3'h1;
            sh_in <= next_in;
        end
    end

    // Opcode, width and address capture
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opcode <= 8'h00;
            width <= SNF_W1;
            quad_mode <= 1'b0;
            addr <= 32'h0000_0000;
            addr_left <= 3'h0;
        end else if (!cs_act) begin
            width <= SNF_W1;
            quad_mode <= 1'b0;
        end else if (op_dec) begin
            opcode <= next_in;
            width <= op_width(next_in);
            quad_mode <= op_quad & ~wpe;
            addr <= 32'h0000_0000;
            addr_left <= op_abytes;
        end else if (in_done && state == ST_ADDR) begin
            addr <= addr_n;
            addr_left <= addr_left - 3'h1;
        end
    end

    // Power-up write lockout counter
    assign lockout_o = lock_cnt != 32'(LOCKOUT_CYCLES);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock_cnt <= 32'h0000_0000;
        end else if (lockout_o) begin
            lock_cnt <= lock_cnt + 32'h0000_0001;
        end
    end

    // Array command issue after the last address byte
    wire blk_hit = is_pe && blk_protected(addr_n[15:6], bp, prot[PROT_TB_BIT]);
    wire accept = addr_last && is_exec && write_enable_latch && !wr_block && !busy && !blk_hit;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd_o <= '0;
            cmd_valid_o <= 1'b0;
        end else begin
            cmd_valid_o <= accept;
            if (accept) begin
                cmd_o <= '{opcode: opcode, addr: addr_n};
            end
        end
    end

    // Busy while the array works; remember whether it programs or erases
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy <= 1'b0;
            pe_op <= 1'b0;
        end else if (accept) begin
            busy <= 1'b1;
            pe_op <= is_pe;
        end else if (op_done_i) begin
            busy <= 1'b0;
        end
    end

    // Write-enable latch
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            write_enable_latch <= 1'b0;
        end else if (op_done_i && busy && pe_op) begin
            write_enable_latch <= 1'b0;
        end else if (op_dec && next_in == OP_WREN && !wr_block) begin
            write_enable_latch <= 1'b1;
        end else if (op_dec && next_in == OP_WRDI) begin
            write_enable_latch <= 1'b0;
        end
    end

    // Register write permission, protect pin sampled at the data byte
    wire sw_gated = srp == SRP_SW_GATED && !wpe && wp_low;
    wire locked = srp == SRP_LOCKDOWN;
    wire base_ok = write_enable_latch && !wr_block;
    wire prot_ok = base_ok && !sw_gated && !locked;
    wire reg_wr = din_byte && is_wrreg;

    // Only the first data byte of a register write counts
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prot <= PROT_RESET;
            conf <= CONF_RESET;
        end else if (reg_wr && addr[7:0] == REG_PROT && prot_ok) begin
            prot <= next_in;
        end else if (reg_wr && addr[7:0] == REG_CONF && base_ok) begin
            conf <= next_in;
        end
    end

    // Status register three is read-only
    always_comb begin
        stat3 = 8'h00;
        stat3[STAT3_BUSY_BIT] = busy;
        stat3[STAT3_WEL_BIT] = write_enable_latch;
    end
    assign regs_o = '{prot: prot, conf: conf, stat3: stat3};

    // Program-load bytes go through the buffer; the link cannot stall
    wire push = din_byte && !is_wrreg;
    snf_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_data_i(next_in),
        .in_valid_i(push),
        .in_ready_o(fifo_ready),
        .out_data_o(load_data_o),
        .out_valid_o(load_valid_o),
        .out_ready_i(load_ready_i)
    );

    // A full buffer drops the byte; flag stays until the next load opcode
    wire load_op = op_dec && addr_bytes(next_in) == 3'h2;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            overflow <= 1'b0;
        end else if (push && !fifo_ready) begin
            overflow <= 1'b1;
        end else if (load_op) begin
            overflow <= 1'b0;
        end
    end
    assign load_overflow_o = overflow;

    // Output byte source
    always_comb begin
        case (addr[7:0])
            REG_PROT: reg_byte = prot;
            REG_CONF: reg_byte = conf;
            REG_STAT3: reg_byte = stat3;
            default: reg_byte = 8'h00;
        endcase
    end
    assign byte_out = is_rdreg ? reg_byte : (rd_valid_i ? rd_data_i : 8'hFF);
    wire out_load = fall && state == ST_DOUT && out_cnt == 3'h0;
    assign rd_ready_o = out_load && !is_rdreg && rd_valid_i;

    // Output shifter moves on falling edges only
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_sh <= 8'h00;
            out_cnt <= 3'h0;
            out_on <= 1'b0;
        end else if (!cs_act) begin
            out_cnt <= 3'h0;
            out_on <= 1'b0;
        end else if (fall && state == ST_DOUT) begin
            out_on <= 1'b1;
            out_cnt <= (out_cnt == last_edge(width)) ? 3'h0 : out_cnt + 3'h1;
            if (out_load) begin
                out_sh <= byte_out;
            end else if (width == SNF_W4) begin
                out_sh <= {out_sh[3:0], 4'h0};
            end else if (width == SNF_W2) begin
                out_sh <= {out_sh[5:0], 2'h0};
            end else begin
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

    // Pin drive; released while paused or deselected
    wire drive = out_on && cs_act && !paused && state == ST_DOUT;
    always_comb begin
        io_o = 4'h0;
        io_oe_o = 4'h0;
        case (width)
            SNF_W2: begin
                io_o[1:0] = out_sh[7:6];
                io_oe_o = 4'h3;
            end
            SNF_W4: begin
                io_o = out_sh[7:4];
                io_oe_o = 4'hF;
            end
            default: begin
                io_o[1] = out_sh[7];
                io_oe_o = 4'h2;
            end
        endcase
        if (!drive) begin
            io_oe_o = 4'h0;
        end
    end

    assign paused_o = paused;
endmodule
`default_nettype wire

// ===== core/snf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module snf_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_i, // System clock
    input wire logic arst_n_i, // Asynchronous reset
    input wire logic [W-1:0] d_i, // Foreign levels
    output logic [W-1:0] q_o // Synchronised levels
);
    logic [W-1:0] meta;
    logic [W-1:0] q;

    // Two stages; only the second one is visible
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d_i;
            q <= meta;
        end
    end

    assign q_o = q;
endmodule
`default_nettype wire

// ===== include/snf_pkg.sv
package snf_pkg;
    // Instruction opcodes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDREG_A = 8'h05;
    localparam logic [7:0] OP_RDREG_B = 8'h0F;
    localparam logic [7:0] OP_WRREG_A = 8'h01;
    localparam logic [7:0] OP_WRREG_B = 8'h1F;
    localparam logic [7:0] OP_PLOAD = 8'h02;
    localparam logic [7:0] OP_PLOAD_Q = 8'h32;
    localparam logic [7:0] OP_PLOAD_QR = 8'h34;
    localparam logic [7:0] OP_PEXEC = 8'h10;
    localparam logic [7:0] OP_ERASE = 8'hD8;
    localparam logic [7:0] OP_BBM = 8'hA1;
    localparam logic [7:0] OP_READ_S = 8'h0B;
    localparam logic [7:0] OP_READ_D = 8'h3B;
    localparam logic [7:0] OP_READ_DIO = 8'hBB;
    localparam logic [7:0] OP_READ_Q = 8'h6B;
    localparam logic [7:0] OP_READ_QIO = 8'hEB;
    // Register addresses carried after the register opcodes
    localparam logic [7:0] REG_PROT = 8'hA0;
    localparam logic [7:0] REG_CONF = 8'hB0;
    localparam logic [7:0] REG_STAT3 = 8'hC0;
    // Protection register fields
    localparam int PROT_REG_PROTECT_BIT0_BIT = 7;
    localparam int PROT_BP_LSB = 3;
    localparam int PROT_TB_BIT = 2;
    localparam int PROT_WPE_BIT = 1;
    localparam int PROT_REG_PROTECT_BIT1_BIT = 0;
    // Status register three fields
    localparam int STAT3_BUSY_BIT = 0;
    localparam int STAT3_WEL_BIT = 1;
    // Values after reset; whole array protected
    localparam logic [7:0] PROT_RESET = 8'h78;
    localparam logic [7:0] CONF_RESET = 8'h00;
    localparam logic [3:0] BP_ALL = 4'hA;
    localparam logic [1:0] SRP_SW_GATED = 2'h1;
    localparam logic [1:0] SRP_LOCKDOWN = 2'h2;
    // Synchroniser reset image: chip select idle high
    localparam logic [5:0] SYNC_INIT = 6'h20;
    // Power-up write lockout
    localparam int CLK_PERIOD_NS = 40;
    localparam int POWERUP_WRITE_LOCKOUT_NS = 5000000;
    localparam int LOCKOUT_CYCLES =
        (POWERUP_WRITE_LOCKOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Program-load buffer
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {SNF_W1, SNF_W2, SNF_W4} snf_width_t;
    typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DIN, ST_DOUT, ST_IGN} snf_state_t;
    typedef struct packed {
        logic [7:0] opcode;
        logic [31:0] addr;
    } snf_cmd_t;
    typedef struct packed {
        logic [7:0] prot;
        logic [7:0] conf;
        logic [7:0] stat3;
    } snf_regs_t;
endpackage

// ===== tb/snf_front_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the front end
module snf_front_assertions import snf_pkg::*; (
    input wire logic clk_i, // Clock
    input wire logic arst_n_i, // Reset
    input wire logic cs_n_i, // Select
    input wire logic [3:0] io_oe_o, // Drive enables
    input wire snf_cmd_t cmd_o, // Command
    input wire logic cmd_valid_o, // Command pulse
    input wire logic op_done_i, // Operation done
    input wire snf_regs_t regs_o, // Registers
    input wire logic paused_o, // Pause
    input wire logic lockout_o // Lockout
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_cmd_one_pulse: assert property (cmd_valid_o |=> !cmd_valid_o)
        else $error("command pulse too long");
    a_cmd_needs_wel: assert property (cmd_valid_o |-> $past(regs_o.stat3[1]) && !lockout_o)
        else $error("command without write enable");
    a_done_drops_wel: assert property (regs_o.stat3[0] && op_done_i && cmd_o.opcode != OP_BBM
        |=> !regs_o.stat3[1]) else $error("latch kept after done");
    a_lockout_no_wel: assert property (lockout_o |-> !regs_o.stat3[1])
        else $error("latch set in lockout");
    a_pause_quiet: assert property (paused_o |-> io_oe_o == 4'h0)
        else $error("driving while paused");
    a_deselect_idle: assert property (cs_n_i [*6] |-> io_oe_o == 4'h0 && !cmd_valid_o)
        else $error("active while deselected");
    a_hwprot_no_quad: assert property (regs_o.prot[1] |-> io_oe_o != 4'hF)
        else $error("quad drive under protection");
    a_oe_shape: assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("odd drive enable");
endmodule
bind snf_front snf_front_assertions i_chk (.clk_i, .arst_n_i, .cs_n_i, .io_oe_o, .cmd_o,
    .cmd_valid_o, .op_done_i, .regs_o, .paused_o, .lockout_o);
`default_nettype wire

// ===== tb/snf_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host end of the link; clock stands at its idle level between frames
module snf_host (
    input wire logic clk_i, // Clock
    input wire logic [3:0] io_i, // Resolved lines
    output logic cs_n_o, // Select
    output logic sclk_o, // Serial clock
    output logic [3:0] hv_o // Host levels
);
    logic [7:0] txq[$];
    logic [7:0] rb;
    logic cpol = 0;
    int pause_at = -1;
    event got;
    initial begin
        cs_n_o = 1;
        sclk_o = 0;
        hv_o = 4'hD;
    end
    // Line 1 carries no host data: noise toggled every clock, not a held value
    always @(posedge clk_i) hv_o[1] <= ~hv_o[1];
    // Frame: bytes of txq out, then nrd bytes in, MSB first
    task automatic run(input int nrd);
        sclk_o <= cpol;
        @(posedge clk_i);
        cs_n_o <= 0;
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < txq.size() + nrd; i++) begin
            for (int k = 7; k >= 0; k--) begin
                sclk_o <= 0;
                hv_o[0] <= (i < txq.size()) ? txq[i][k] : ~hv_o[0];
                repeat (4) @(posedge clk_i);
                if (i == pause_at && k == 7) begin
                    hv_o[3] <= 0;
                    repeat (4) @(posedge clk_i);
                    sclk_o <= 1; // Edge to be ignored
                    repeat (4) @(posedge clk_i);
                    sclk_o <= 0;
                    repeat (4) @(posedge clk_i);
                    hv_o[3] <= 1;
                    repeat (4) @(posedge clk_i);
                end
                sclk_o <= 1;
                repeat (4) @(posedge clk_i);
                rb = {rb[6:0], io_i[1]};
            end
        end
        sclk_o <= cpol;
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1;
        txq.delete();
        pause_at = -1;
        repeat (8) @(posedge clk_i);
        if (nrd > 0) ->got;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import snf_pkg::*;
    logic clk_i = 0, arst_n_i = 0, op_done_i = 0, load_ready_i = 0;
    logic cs_n, sclk, cmd_valid, load_valid, ovf;
    logic [3:0] io_o, io_oe, hv;
    logic [7:0] load_data, v;
    logic [7:0] rd_data = 8'hFF;
    logic rd_valid = 0, paused, lockout;
    snf_regs_t regs;
    snf_cmd_t cmd;
    logic [7:0] expq[$];
    int failures = 0, comparisons = 0, cyc = 0, seed = 32'h2EB6;
    // Device wins where it drives, the host elsewhere
    wire [3:0] io_w = (io_oe & io_o) | (~io_oe & hv);
    initial forever #20 clk_i = ~clk_i;
    snf_front #(.LOCKOUT_CYCLES(400)) i_snf_front (.clk_i, .arst_n_i, .cs_n_i(cs_n),
        .sclk_i(sclk), .io_i(io_w), .io_o, .io_oe_o(io_oe), .cmd_o(cmd), .cmd_valid_o(cmd_valid),
        .op_done_i, .rd_data_i(rd_data), .rd_valid_i(rd_valid), .rd_ready_o(),
        .load_data_o(load_data), .load_valid_o(load_valid), .load_ready_i,
        .load_overflow_o(ovf), .regs_o(regs), .paused_o(paused), .lockout_o(lockout));
    snf_host i_snf_host (.clk_i, .io_i(io_w), .cs_n_o(cs_n), .sclk_o(sclk), .hv_o(hv));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        i_snf_host.txq = {op, a};
        i_snf_host.run(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_snf_host.txq = {OP_WREN};
        i_snf_host.run(0);
        i_snf_host.txq = {OP_WRREG_A, a, d};
        i_snf_host.run(0);
    endtask
    // Results are matched against the oldest note as they appear
    always @(i_snf_host.got) check("register", i_snf_host.rb, expq.pop_front());
    always @(posedge clk_i) begin
        if (cmd_valid) check("command", cmd.opcode, expq.pop_front());
        if (load_valid && load_ready_i) check("load", load_data, expq.pop_front());
        cyc++;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1;
        i_snf_host.txq = {OP_WREN};
        i_snf_host.run(0);
        check("lockout", {7'h0, lockout}, 8'h01);
        check("paused", {7'h0, paused}, 8'h00);
        rd(OP_RDREG_A, REG_STAT3, 8'h00);
        repeat (400) @(posedge clk_i);
        // Both clock modes and both read opcodes; first frame paused at the opcode, second at the address byte
        for (int m = 0; m < 2; m++) begin
            i_snf_host.cpol = m[0];
            i_snf_host.pause_at = m;
            rd(m ? OP_RDREG_B : OP_RDREG_A, REG_PROT, PROT_RESET);
        end
        v = 8'($random(seed));
        wr(REG_CONF, v);
        rd(OP_RDREG_A, REG_CONF, v);
        wr(REG_PROT, 8'h00);
        rd(OP_RDREG_B, REG_STAT3, 8'h02);
        expq.push_back(OP_PEXEC);
        i_snf_host.txq = {OP_PEXEC, 8'h00, 8'h00, 8'h40};
        i_snf_host.run(0);
        op_done_i <= 1;
        @(posedge clk_i);
        op_done_i <= 0;
        rd(OP_RDREG_A, REG_STAT3, 8'h00);
        // Seventeen bytes into a sixteen-word buffer with the consumer stalled
        i_snf_host.txq = {OP_PLOAD, 8'h00, 8'h00};
        for (int i = 0; i < 17; i++) begin
            v = 8'($random(seed));
            i_snf_host.txq.push_back(v);
            if (i < 16) expq.push_back(v);
        end
        i_snf_host.run(0);
        check("overflow", {7'h0, ovf}, 8'h01);
        repeat (80) @(posedge clk_i) load_ready_i <= 1'($random(seed));
        check("drained", 8'(expq.size()), 8'h00);
        wr(REG_PROT, 8'h02);
        rd(OP_RDREG_A, REG_PROT, 8'h02);
        check("protect image", regs.prot, 8'h02);
        check("lockout end", {7'h0, lockout}, 8'h00);
        i_snf_host.txq = {OP_READ_Q, 8'h00, 8'h00, 8'h00, 8'h00};
        i_snf_host.run(0);
        report_and_stop();
    end
endmodule
`default_nettype wire
